// >>> ued_pkg.sv
// Package of constants and carrier types for the endpoint DMA request block.
package ued_pkg;
  // Clock period and bit time, both in nanoseconds.
  localparam int CLK_PERIOD_NS = 40;
  localparam int BIT_TIME_NS = 84;
  // A bit time is a least gap, so it rounds up to whole clock cycles.
  localparam int BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Base enable time of the request, in clock cycles.
  localparam int BASE_CYC = 1;
  // Register offsets on the local bus.
  localparam logic [7:0] ADR_CTL0 = 8'h10;
  localparam logic [7:0] ADR_INT0 = 8'h11;
  localparam logic [7:0] ADR_CTL1 = 8'h12;
  localparam logic [7:0] ADR_INT1 = 8'h13;
  localparam logic [7:0] ADR_RDY = 8'h20;
  localparam logic [7:0] ADR_MODE = 8'h21;
  localparam logic [7:0] ADR_T4L = 8'h22;
  localparam logic [7:0] ADR_T4H = 8'h23;
  localparam logic [7:0] ADR_T5L = 8'h24;
  localparam logic [7:0] ADR_T5H = 8'h25;
  localparam logic [7:0] ADR_POL = 8'h30;
  localparam logic [7:0] ADR_DAT0 = 8'h40;
  localparam logic [7:0] ADR_DAT1 = 8'h41;
  // Channel control fields.
  localparam int CTL_EN = 0;
  localparam int CTL_DUAL = 1;
  localparam int CTL_DEMAND = 4;
  localparam int CTL_SEL_LSB = 5;
  localparam int CTL_HALT = 7;
  // Polarity fields: request of channel c at bit c, acknowledge at bit 2+c.
  localparam int POL_ACK_LSB = 2;
  // Reset values.
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] INT_RST = 8'h00;
  localparam logic [7:0] POL_RST = 8'h00;
  // Endpoint FIFO capacities in bytes.
  localparam logic [9:0] CAP_BULK = 10'h040;
  localparam logic [9:0] CAP_ISO5 = 10'h200;
  localparam logic [9:0] CAP_ISO6 = 10'h100;
  // Depth of the transmit staging FIFO.
  localparam int FIFO_DEPTH = 32;
  // Endpoint view from the protocol engine.
  typedef struct packed {
    logic is_tx;
    logic iso;
    logic [9:0] max_pkt;
    logic [9:0] rx_cnt;
  } ued_ep_s;
  // One staged transmit byte with its endpoint index.
  typedef struct packed {
    logic [1:0] ep;
    logic [7:0] data;
  } ued_word_s;
  // Local bus register access, already in this clock domain.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ued_regreq_s;
endpackage

// >>> ued_dma_request.sv
// Two-channel DMA request logic with its transmit staging FIFO.
// How it works
// - Four polarity bits set request/acknowledge levels.
// - Reset: requests active-low, acknowledges active-high.
// - Transmit endpoint ready for data raises request.
// - Transmit packet ready set drops request.
// - Host ACK clears transmit ready, request returns.
// - Good received packet sets ready, raises request.
// - Reader writes 1 to clear; request drops.
// - Enable bit 0 gates the request.
// - Bits 6:5 pick endpoint 1, 2, 4, 5.
// - Endpoints 0 and 3 never request DMA.
// - Same endpoint on both channels: identical behaviour.
// - Bit 1 dual address mode ignores acknowledge.
// - Bit 4 picks single or demand transfer.
// - Demand request holds until packet fully moved; code drops it while the staging FIFO is full.
// - Single mode drops request after each byte.
// - Isochronous FIFOs: 512 bytes, or 256 each.
// - Isochronous FIFOs have two alternating layers.
// - CRC error latches isochronous received byte count.
// - Full-size DMA write sets transmit ready itself.
// - Single mode gap is base plus n bit times.
`timescale 1ns/1ps

// Staging FIFO with valid and ready on both sides.
module ued_fifo
  import ued_pkg::*;
#(
  parameter int W = 10,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // Pointers wrap freely, so the depth must be a power of two.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_chk
    $error("FIFO depth must be a power of two of at least two.");
  end
  logic [W-1:0] mem [DEPTH]; // Storage words.
  logic [AW-1:0] wp_q; // Write pointer.
  logic [AW-1:0] rp_q; // Read pointer.
  logic [AW:0] cnt_q; // Words held.
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = cnt_q != (AW + 1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rp_q];
  // Pointers and fill level move on every accepted push and pop.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wp_q] <= in_data;
        wp_q <= wp_q + 1'b1;
      end
      if (pop)
      begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

// Request and acknowledge logic for two DMA channels over four endpoints.
module ued_dma_request
  import ued_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire ued_regreq_s reg_req,
  output logic [7:0] reg_rdata,
  input wire ued_ep_s ep_stat [4],
  input wire logic [3:0] usb_tx_acked,
  input wire logic [3:0] usb_rx_good,
  input wire logic [1:0] iso_crc_err,
  input wire logic [9:0] iso_rx_bytes,
  input wire logic [7:0] dma_wdata,
  input wire logic dma_acknowledge_ch0,
  input wire logic dma_acknowledge_ch1,
  output logic dma_request_ch0_n,
  output logic dma_request_ch1_n,
  output logic ep_wr_valid,
  output ued_word_s ep_wr_word,
  input wire logic ep_wr_ready,
  output logic [3:0] pkt_ready,
  output logic [1:0] iso_layer,
  output logic six_endpoint_mode
);
  // Endpoint capacity in bytes for index e (EP1, EP2, EP4, EP5).
  function automatic logic [9:0] cap_of(input int e, input logic iso, input logic six);
    logic [9:0] c;
    c = CAP_BULK;
    if (iso && e == 2)
    begin
      c = six ? CAP_ISO6 : CAP_ISO5;
    end
    if (iso && e == 3)
    begin
      c = CAP_ISO6;
    end
    return c;
  endfunction

  wire rst = sys_rst | soft_rst; // Both resets restore the same state.
  logic [7:0] ctl_q [2]; // Channel control registers.
  logic [7:0] intvl_q [2]; // Channel interval registers.
  logic [7:0] pol_q; // Pin polarity select.
  logic six_q; // Six-endpoint mode.
  logic [3:0] rdy_q; // Packet ready flags per endpoint.
  logic [9:0] cnt_q [4]; // Bytes moved in the current packet.
  logic [9:0] gap_q [2]; // Single mode gap countdown.
  logic [9:0] tmp_q [2]; // Temporary received counts for EP4 and EP5.
  logic [1:0] layer_q; // Local-side layer of EP4 and EP5.
  logic [1:0] req_q; // Active-high requests.
  logic [1:0] pin_q; // Request pin levels.
  logic [7:0] rdata_q; // Read data.
  logic [1:0] ack_s1_q; // Acknowledge synchroniser, first stage.
  logic [1:0] ack_s2_q; // Acknowledge synchroniser, second stage.
  logic [1:0] ack_s3_q; // Previous second stage, for edges.
  logic [7:0] dat_s1_q; // Data pin synchroniser, first stage.
  logic [7:0] dat_s2_q; // Data pin synchroniser, second stage.
  logic [1:0] ack_act; // Acknowledge in active-high sense.
  logic [1:0] ack_old; // Previous acknowledge, active-high sense.
  logic [1:0] xfer; // One byte moved on a channel.
  logic [1:0] sel [2]; // Selected endpoint index per channel.
  logic [1:0] req_c; // Next request value.
  logic [9:0] lim [4]; // Bytes in a full packet.
  logic [3:0] hit, sw_w1, rdy_set, rdy_clr, base, fall;
  logic fifo_in_rdy;
  logic [7:0] rd_mux;

  // Acknowledge and data pins cross in through two flip-flops each.
  // The data is assumed stable around the acknowledge pulse.
  always_ff @(posedge clk)
  begin
    ack_s1_q <= {dma_acknowledge_ch1, dma_acknowledge_ch0};
    ack_s2_q <= ack_s1_q;
    ack_s3_q <= ack_s2_q;
    dat_s1_q <= dma_wdata;
    dat_s2_q <= dat_s1_q;
  end

  wire rdy_wr = reg_req.wr && reg_req.addr == ADR_RDY;

  // Per-channel decode.
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    assign sel[c] = ctl_q[c][CTL_SEL_LSB +: 2];
    assign ack_act[c] = ack_s2_q[c] ^ pol_q[POL_ACK_LSB + c];
    assign ack_old[c] = ack_s3_q[c] ^ pol_q[POL_ACK_LSB + c];
    wire dat_acc = (reg_req.wr || reg_req.rd) && reg_req.addr == (ADR_DAT0 + 8'(c));
    // Dual address mode counts data port accesses and ignores acknowledge.
    assign xfer[c] = ctl_q[c][CTL_EN] &
                     (ctl_q[c][CTL_DUAL] ? dat_acc : (ack_act[c] & ~ack_old[c]));
    // Request: enabled, not halted, endpoint ready; single mode also waits out the byte and the gap.
    assign req_c[c] = ctl_q[c][CTL_EN] & ~ctl_q[c][CTL_HALT] & base[sel[c]] &
                      (ctl_q[c][CTL_DEMAND] | ((gap_q[c] == '0) & ~hit[sel[c]]));
  end

  // Per-endpoint packet tracking; both channels act on the endpoint, not the channel.
  for (genvar e = 0; e < 4; e++)
  begin : g_ep
    wire tx = ep_stat[e].is_tx;
    wire [9:0] cap = cap_of(e, ep_stat[e].iso, six_q);
    wire ok = (e != 3) || six_q;
    assign lim[e] = tx ? ((ep_stat[e].max_pkt < cap) ? ep_stat[e].max_pkt : cap) : ep_stat[e].rx_cnt;
    // Either channel's acknowledge counts for the endpoint it serves.
    assign hit[e] = ((xfer[0] && sel[0] == 2'(e)) || (xfer[1] && sel[1] == 2'(e))) &&
                    (!tx || fifo_in_rdy);
    assign sw_w1[e] = rdy_wr & reg_req.wdata[e];
    // Full-size DMA write or a software write sets transmit ready.
    assign rdy_set[e] = tx ? ((hit[e] && cnt_q[e] + 10'h001 == lim[e]) || sw_w1[e])
                           : usb_rx_good[e];
    assign rdy_clr[e] = tx ? usb_tx_acked[e] : sw_w1[e];
    assign fall[e] = rdy_q[e] & rdy_clr[e] & ~rdy_set[e];
    // Transmit wants room; receive wants unread bytes of a ready packet.
    assign base[e] = ok & (tx ? (~rdy_q[e] & fifo_in_rdy)
                              : (rdy_q[e] & cnt_q[e] < lim[e]));
  end

  // Packet ready flags; a set in the same cycle as a clear wins.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdy_q <= 4'h0;
    end
    else
    begin
      rdy_q <= rdy_set | (rdy_q & ~rdy_clr);
    end
  end

  // Byte counters restart when a packet is handed over.
  always_ff @(posedge clk)
  begin
    for (int e = 0; e < 4; e++)
    begin
      if (rst || (ep_stat[e].is_tx ? rdy_set[e] : rdy_clr[e]))
      begin
        cnt_q[e] <= '0;
      end
      else if (hit[e])
      begin
        cnt_q[e] <= cnt_q[e] + 10'h001;
      end
    end
  end

  // Gap after each single-mode byte, loaded when the served endpoint moves.
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (rst)
      begin
        gap_q[c] <= '0;
      end
      else if (hit[sel[c]] && !ctl_q[c][CTL_DEMAND])
      begin
        gap_q[c] <= 10'(BASE_CYC) + 10'(intvl_q[c]) * 10'(BIT_CYC);
      end
      else if (gap_q[c] != '0)
      begin
        gap_q[c] <= gap_q[c] - 10'h001;
      end
    end
  end

  // Requests and pins; pins idle high as reset leaves polarity active-low.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_q <= 2'h0;
      pin_q <= 2'h3;
    end
    else
    begin
      req_q <= req_c;
      pin_q <= ~(req_c ^ pol_q[1:0]);
    end
  end

  // Isochronous CRC byte count capture and layer swap on hand-back.
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (rst)
      begin
        tmp_q[i] <= '0;
        layer_q[i] <= 1'b0;
      end
      else
      begin
        if (iso_crc_err[i])
        begin
          tmp_q[i] <= iso_rx_bytes;
        end
        if (ep_stat[2 + i].iso && fall[2 + i])
        begin
          layer_q[i] <= ~layer_q[i];
        end
      end
    end
  end

  // Register writes; the polarity and control registers reset to zero.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctl_q[0] <= CTL_RST;
      ctl_q[1] <= CTL_RST;
      intvl_q[0] <= INT_RST;
      intvl_q[1] <= INT_RST;
      pol_q <= POL_RST;
      six_q <= 1'b0;
    end
    else if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        ADR_CTL0: ctl_q[0] <= reg_req.wdata;
        ADR_CTL1: ctl_q[1] <= reg_req.wdata;
        ADR_INT0: intvl_q[0] <= reg_req.wdata;
        ADR_INT1: intvl_q[1] <= reg_req.wdata;
        ADR_POL: pol_q <= {4'h0, reg_req.wdata[3:0]};
        ADR_MODE: six_q <= reg_req.wdata[0];
        default: ;
      endcase
    end
  end

  // Read selection; unmapped addresses read as zero.
  assign rd_mux = reg_req.addr == ADR_CTL0 ? ctl_q[0] :
                  reg_req.addr == ADR_CTL1 ? ctl_q[1] :
                  reg_req.addr == ADR_INT0 ? intvl_q[0] :
                  reg_req.addr == ADR_INT1 ? intvl_q[1] :
                  reg_req.addr == ADR_POL ? pol_q :
                  reg_req.addr == ADR_RDY ? {4'h0, rdy_q} :
                  reg_req.addr == ADR_MODE ? {2'h0, layer_q, 3'h0, six_q} :
                  reg_req.addr == ADR_T4L ? tmp_q[0][7:0] :
                  reg_req.addr == ADR_T4H ? {6'h00, tmp_q[0][9:8]} :
                  reg_req.addr == ADR_T5L ? tmp_q[1][7:0] :
                  reg_req.addr == ADR_T5H ? {6'h00, tmp_q[1][9:8]} : 8'h00;

  // Read data is held until the next read.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
    end
    else if (reg_req.rd)
    begin
      rdata_q <= rd_mux;
    end
  end

  // Transmit bytes stage here; a full FIFO holds the transmit requests off.
  wire fifo_push = |(hit & {ep_stat[3].is_tx, ep_stat[2].is_tx, ep_stat[1].is_tx, ep_stat[0].is_tx});
  wire [7:0] xd0 = ctl_q[0][CTL_DUAL] ? reg_req.wdata : dat_s2_q;
  wire [7:0] xd1 = ctl_q[1][CTL_DUAL] ? reg_req.wdata : dat_s2_q;
  ued_word_s fifo_in;
  assign fifo_in = xfer[0] ? ued_word_s'{ep: sel[0], data: xd0} : ued_word_s'{ep: sel[1], data: xd1};
  ued_fifo #(.W($bits(ued_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_push),
    .in_data(fifo_in),
    .in_ready(fifo_in_rdy),
    .out_valid(ep_wr_valid),
    .out_data(ep_wr_word),
    .out_ready(ep_wr_ready)
  );

  assign reg_rdata = rdata_q;
  assign dma_request_ch0_n = pin_q[0];
  assign dma_request_ch1_n = pin_q[1];
  assign pkt_ready = rdy_q;
  assign iso_layer = layer_q;
  assign six_endpoint_mode = six_q;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_low2;
    !req_q[0] ##1 !req_q[0];
  endsequence
  property p_pin_pol;
    req_q[0] |-> pin_q[0] == pol_q[0];
  endproperty
  a_pin_pol: assert property (p_pin_pol) else $error("Request pin level wrong.");
  property p_rst_idle;
    disable iff (1'b0) sys_rst |=> pin_q == 2'h3 && pol_q == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("Pins not idle after reset.");
  property p_en_off;
    !ctl_q[0][CTL_EN] |=> !req_q[0];
  endproperty
  a_en_off: assert property (p_en_off) else $error("Request while disabled.");
  property p_tx_drop;
    (rdy_set[sel[0]] && ep_stat[sel[0]].is_tx && $stable(ctl_q[0])) |-> ##2 !req_q[0];
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("Request held after ready.");
  property p_ack_clr;
    (usb_tx_acked[0] && ep_stat[0].is_tx && !rdy_set[0]) |=> !rdy_q[0];
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("Transmit ready not cleared.");
  property p_rx_set;
    (usb_rx_good[1] && !ep_stat[1].is_tx) |=> rdy_q[1];
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("Receive ready not set.");
  property p_same;
    (ctl_q[0] == ctl_q[1] && intvl_q[0] == intvl_q[1] && gap_q[0] == gap_q[1] &&
     pol_q[0] == pol_q[1]) |=> req_q[0] == req_q[1] && pin_q[0] == pin_q[1];
  endproperty
  a_same: assert property (p_same) else $error("Shared endpoint channels differ.");
  property p_single_gap;
    (hit[sel[0]] && !ctl_q[0][CTL_DEMAND] && $stable(ctl_q[0])) |=> s_low2;
  endproperty
  a_single_gap: assert property (p_single_gap) else $error("No gap after byte.");
  property p_crc;
    iso_crc_err[0] |=> tmp_q[0] == $past(iso_rx_bytes);
  endproperty
  a_crc: assert property (p_crc) else $error("CRC byte count not held.");
endmodule

// >>> ued_dma_partner.sv
// Behavioural model of the local-bus DMA controller serving one request channel.
`timescale 1ns/1ps

module ued_dma_partner
  import ued_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic slow,
  input wire logic req_pol,
  input wire logic ack_pol,
  input wire logic req_pin,
  output logic ack_pin,
  output logic [7:0] data_pin,
  output logic [7:0] sent
);
  // Active-high acknowledge before the pin polarity is applied.
  logic ack_act;

  // The acknowledge pin is inverted when its polarity bit is 1.
  assign ack_pin = ack_act ^ ack_pol;

  // One byte per acknowledge pulse, and only while the request is seen active.
  initial
  begin
    ack_act = 1'b0;
    data_pin = 8'h5A;
    sent = 8'h00;
    forever
    begin
      @(posedge clk);
      #1;
      if (rst)
      begin
        sent = 8'h00;
      end
      else if (go && (req_pin === req_pol))
      begin
        data_pin = 8'hA0 + sent;
        // Counted when offered, so the count is settled before the byte lands.
        sent = sent + 8'h01;
        ack_act = 1'b1;
        // Held three edges so the two-flop synchroniser sees stable data.
        repeat (3) @(posedge clk);
        #1;
        ack_act = 1'b0;
        // Released data lines must not keep the last value, so invert it.
        data_pin = ~data_pin;
        // The wait outlasts the request drop after the last byte of a packet.
        repeat (slow ? 9 : 6) @(posedge clk);
      end
    end
  end
endmodule

// >>> testbench.sv
// Self-checking testbench for the endpoint DMA request block.
`timescale 1ns/1ps

module testbench
  import ued_pkg::*;
;
  logic clk, sys_rst, soft_rst, go, slow;
  ued_regreq_s reg_req;
  logic [7:0] reg_rdata, dma_wdata, sent;
  ued_ep_s ep_stat [4];
  logic [3:0] usb_tx_acked, usb_rx_good, pkt_ready, pol_q;
  logic [1:0] iso_crc_err, iso_layer;
  logic [9:0] iso_rx_bytes;
  logic dma_acknowledge_ch0, dma_acknowledge_ch1, dma_request_ch0_n, dma_request_ch1_n;
  logic ep_wr_valid, ep_wr_ready, six_endpoint_mode;
  ued_word_s ep_wr_word;
  // Bytes popped from the staging FIFO, in order.
  ued_word_s popq [$];
  int n_mismatch, n_tests, cycles;

  ued_dma_request u_ued_dma_request (.clk(clk), .sys_rst(sys_rst), .soft_rst(soft_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .ep_stat(ep_stat), .usb_tx_acked(usb_tx_acked), .usb_rx_good(usb_rx_good),
    .iso_crc_err(iso_crc_err), .iso_rx_bytes(iso_rx_bytes), .dma_wdata(dma_wdata),
    .dma_acknowledge_ch0(dma_acknowledge_ch0), .dma_acknowledge_ch1(dma_acknowledge_ch1),
    .dma_request_ch0_n(dma_request_ch0_n), .dma_request_ch1_n(dma_request_ch1_n), .ep_wr_valid(ep_wr_valid),
    .ep_wr_word(ep_wr_word), .ep_wr_ready(ep_wr_ready), .pkt_ready(pkt_ready), .iso_layer(iso_layer),
    .six_endpoint_mode(six_endpoint_mode));

  ued_dma_partner u_ued_dma_partner (.clk(clk), .rst(sys_rst), .go(go), .slow(slow), .req_pol(pol_q[0]),
    .ack_pol(pol_q[2]), .req_pin(dma_request_ch0_n), .ack_pin(dma_acknowledge_ch0), .data_pin(dma_wdata),
    .sent(sent));

  // A 40 ns clock.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Records every byte that the endpoint side accepts.
  always @(posedge clk)
  begin
    if (ep_wr_valid && ep_wr_ready)
      popq.push_back(ep_wr_word);
  end

  // Cuts a hang short; the run needs well under two thousand cycles.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Every task starts and ends just after a rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    if (a == ADR_POL)
      pol_q = d[3:0];
    cyc(1);
    reg_req.wr = 1'b0;
    cyc(1);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    reg_req.rd = 1'b0;
    cyc(1);
    check(nm, reg_rdata, exp);
  endtask

  task automatic pulse(input logic [3:0] tx, input logic [3:0] rx);
    usb_tx_acked = tx;
    usb_rx_good = rx;
    cyc(1);
    usb_tx_acked = 4'h0;
    usb_rx_good = 4'h0;
    cyc(1);
  endtask

  function automatic logic pin(input int ch);
    return ch ? dma_request_ch1_n : dma_request_ch0_n;
  endfunction

  // Pin level for an active or idle request under the current polarity.
  function automatic logic lvl(input int ch, input logic act);
    return pol_q[ch] ? act : !act;
  endfunction

  task automatic wait_pin(input int ch, input logic act, input int lim, input string nm);
    for (int i = 0; i < lim && pin(ch) !== lvl(ch, act); i++)
      cyc(1);
    check(nm, pin(ch), lvl(ch, act));
  endtask

  // Reset values, read-back and software reset.
  task automatic t_regs();
    check("req0 idle", dma_request_ch0_n, 1'b1);
    chk_rd(ADR_CTL0, CTL_RST, "ctl0 reset");
    chk_rd(ADR_POL, POL_RST, "pol reset");
    chk_rd(8'h7E, 8'h00, "unmapped");
    reg_wr(ADR_POL, 8'h0A);
    reg_wr(ADR_CTL1, 8'h5C);
    chk_rd(ADR_POL, 8'h0A, "pol rw");
    chk_rd(ADR_CTL1, 8'h5C, "ctl1 rw");
    soft_rst = 1'b1;
    cyc(1);
    soft_rst = 1'b0;
    pol_q = 4'h0;
    cyc(1);
    chk_rd(ADR_POL, POL_RST, "pol soft");
    chk_rd(ADR_CTL1, CTL_RST, "ctl1 soft");
    check("req1 soft", dma_request_ch1_n, 1'b1);
  endtask

  // Demand transmit on channel 0, endpoint 1, optionally stalling the endpoint FIFO.
  task automatic t_tx(input logic [3:0] pol, input int n, input logic stall);
    logic [7:0] base;
    int i, idle, on;
    ep_stat[0] = '{is_tx: 1'b1, iso: 1'b0, max_pkt: n[9:0], rx_cnt: 10'h000};
    ep_wr_ready = !stall;
    popq.delete();
    base = sent;
    idle = 0;
    on = 0;
    reg_wr(ADR_POL, {4'h0, pol});
    reg_wr(ADR_CTL0, 8'h11);
    wait_pin(0, 1'b1, 4, "tx req up");
    go = 1'b1;
    if (stall)
    begin
      for (i = 0; i < 600 && sent - base < 8'h20; i++)
        cyc(1);
      cyc(12);
      check("full count", sent - base, 32);
      wait_pin(0, 1'b0, 1, "req off full");
      ep_wr_ready = 1'b1;
    end
    for (i = 0; i < 2000 && pkt_ready[0] !== 1'b1; i++)
    begin
      idle += (pin(0) !== lvl(0, 1'b1));
      cyc(1);
    end
    if (!stall)
      check("demand hold", idle, 0);
    check("tx bytes", sent - base, n);
    check("tx ready", pkt_ready[0], 1'b1);
    wait_pin(0, 1'b0, 3, "tx req drop");
    go = 1'b0;
    for (i = 0; i < 100 && popq.size() < n; i++)
      cyc(1);
    check("fifo count", popq.size(), n);
    for (i = 0; i < popq.size(); i++)
      check("fifo word", popq[i], {2'b00, 8'hA0 + base + i[7:0]});
    pulse(4'h1, 4'h0);
    wait_pin(0, 1'b1, 3, "tx req again");
    check("tx ready clr", pkt_ready[0], 1'b0);
    reg_wr(ADR_CTL0, 8'h10);
    for (i = 0; i < 20; i++)
    begin
      on += (pin(0) === lvl(0, 1'b1));
      cyc(1);
    end
    check("disabled", on, 0);
    reg_wr(ADR_POL, 8'h00);
  endtask

  // Single transfer mode with an interval of two bit times.
  task automatic t_single();
    int i, gap;
    gap = 0;
    ep_stat[0].max_pkt = 10'h003;
    reg_wr(ADR_INT0, 8'h02);
    reg_wr(ADR_CTL0, 8'h01);
    slow = 1'b1;
    go = 1'b1;
    wait_pin(0, 1'b1, 4, "single up");
    for (i = 0; i < 40 && pin(0) === lvl(0, 1'b1); i++)
      cyc(1);
    for (i = 0; i < 100 && pin(0) !== lvl(0, 1'b1); i++)
    begin
      gap++;
      cyc(1);
    end
    check("single gap", gap >= BASE_CYC + BIT_CYC * 2, 1'b1);
    for (i = 0; i < 300 && pkt_ready[0] !== 1'b1; i++)
      cyc(1);
    go = 1'b0;
    slow = 1'b0;
    check("single ready", pkt_ready[0], 1'b1);
    reg_wr(ADR_CTL0, 8'h00);
    pulse(4'h1, 4'h0);
  endtask

  // Dual-address demand receive on channel 1, endpoint 2, with a stray acknowledge.
  task automatic t_rx();
    ep_stat[1] = '{is_tx: 1'b0, iso: 1'b0, max_pkt: 10'h040, rx_cnt: 10'h002};
    reg_wr(ADR_CTL1, 8'h33);
    wait_pin(1, 1'b0, 1, "rx idle");
    pulse(4'h0, 4'h2);
    wait_pin(1, 1'b1, 3, "rx req");
    check("rx ready", pkt_ready[1], 1'b1);
    dma_acknowledge_ch1 = 1'b1;
    cyc(3);
    dma_acknowledge_ch1 = 1'b0;
    cyc(4);
    wait_pin(1, 1'b1, 1, "ack ignored");
    chk_rd(ADR_DAT1, 8'h00, "rx byte");
    chk_rd(ADR_DAT1, 8'h00, "rx byte");
    wait_pin(1, 1'b0, 4, "rx moved");
    reg_wr(ADR_RDY, 8'h02);
    check("rx ready clr", pkt_ready[1], 1'b0);
    wait_pin(1, 1'b0, 1, "rx stays off");
    reg_wr(ADR_CTL1, 8'h00);
  endtask

  // Endpoint selection on channel 1, then both channels on one endpoint.
  task automatic t_select();
    int s, k, diff;
    diff = 0;
    reg_wr(ADR_MODE, 8'h01);
    check("six mode", six_endpoint_mode, 1'b1);
    for (s = 0; s < 4; s++)
      for (k = 0; k < 4; k++)
      begin
        for (int j = 0; j < 4; j++)
          ep_stat[j].is_tx = (j == k);
        reg_wr(ADR_CTL1, {1'b0, s[1:0], 5'h13});
        cyc(2);
        check("ep select", dma_request_ch1_n, s != k);
      end
    ep_stat[0].is_tx = 1'b1;
    reg_wr(ADR_CTL0, 8'h13);
    reg_wr(ADR_CTL1, 8'h13);
    wait_pin(0, 1'b1, 3, "shared up");
    for (s = 0; s < 6; s++)
    begin
      diff += (dma_request_ch0_n !== dma_request_ch1_n);
      cyc(1);
    end
    check("shared pins", diff, 0);
    reg_wr(ADR_CTL0, 8'h00);
    reg_wr(ADR_CTL1, 8'h00);
  endtask

  // Isochronous layer swap and count latch on a CRC error.
  task automatic t_iso();
    logic lay;
    ep_stat[2] = '{is_tx: 1'b1, iso: 1'b1, max_pkt: 10'h100, rx_cnt: 10'h000};
    lay = iso_layer[0];
    reg_wr(ADR_RDY, 8'h04);
    check("iso ready", pkt_ready[2], 1'b1);
    pulse(4'h4, 4'h0);
    check("iso layer", iso_layer[0], !lay);
    for (int k = 0; k < 2; k++)
    begin
      iso_rx_bytes = k ? 10'h0C3 : 10'h1A5;
      iso_crc_err[k] = 1'b1;
      cyc(1);
      iso_crc_err = 2'b00;
      cyc(1);
      chk_rd(k ? ADR_T5L : ADR_T4L, k ? 8'hC3 : 8'hA5, "count lo");
      chk_rd(k ? ADR_T5H : ADR_T4H, k ? 8'h00 : 8'h01, "count hi");
    end
    // Dual-address writes into EP4 stop at its six-endpoint capacity of 256 bytes.
    ep_stat[2].max_pkt = 10'h3FF;
    reg_wr(ADR_CTL0, 8'h53);
    for (int b = 0; b < 256; b++)
    begin
      if (b == 255)
        check("iso cap early", pkt_ready[2], 1'b0);
      reg_wr(ADR_DAT0, b[7:0]);
    end
    check("iso cap full", pkt_ready[2], 1'b1);
    reg_wr(ADR_CTL0, 8'h00);
  endtask

  // Main sequence: reset for five cycles, then each scenario in turn.
  initial
  begin
    {sys_rst, soft_rst, go, slow} = 4'h8;
    reg_req = '0;
    {usb_tx_acked, usb_rx_good, pol_q} = '0;
    {iso_crc_err, iso_rx_bytes, dma_acknowledge_ch1} = '0;
    ep_wr_ready = 1'b1;
    for (int j = 0; j < 4; j++)
      ep_stat[j] = '0;
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_regs();
    t_tx(4'h0, 34, 1'b1);
    t_tx(4'h5, 3, 1'b0);
    t_single();
    t_rx();
    t_select();
    t_iso();
    finish_test();
  end
endmodule
